// ### ldo_ctrl_pkg.sv
// constants, field layout and types for the regulator control register bank
// assumes one 20 MHz clock and synchronous active-high reset
package ldo_ctrl_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] LDO3_CONTROL_ADDR = 8'h6E;
  localparam logic [7:0] LDO4_CONTROL_ADDR = 8'h6F;
  localparam logic [7:0] LDO5_CONTROL_ADDR = 8'h70;
  localparam logic [7:0] LDO6_CONTROL_ADDR = 8'h71;
  localparam int LDO_COUNT = 4;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // serial bus device address, value is arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h08;

  // ==========================================================
  // field positions and reset values
  localparam int VCODE_MSB = 3;
  localparam int VCODE_LSB = 0;
  localparam int OUTPUT_ON_BIT = 4;
  localparam int STANDBY_KEEP_BIT = 5;
  localparam int LOW_POWER_BIT = 6;
  localparam int TOP_BIT = 7;
  localparam logic [7:0] VCODE_DOC_DEFAULT = 8'h80;
  // only the field's own four bits of the printed default are loaded
  localparam logic [3:0] VCODE_RESET = VCODE_DOC_DEFAULT[3:0];
  localparam logic [7:0] CTRL_RESET = {4'h0, VCODE_RESET};

  // ==========================================================
  // set point scale in millivolts
  localparam logic [11:0] BASE_MV = 12'h708;
  localparam logic [11:0] STEP_MV = 12'h064;

  // ==========================================================
  // types
  typedef struct packed {
    logic top;
    logic low_power;
    logic standby_keep;
    logic output_on;
    logic [3:0] voltage_code;
  } ldo_ctrl_t;

  typedef enum logic [1:0] {LDO_OFF, LDO_ON, LDO_LOW_POWER} ldo_mode_t;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_PTR, BUS_ACK_PTR,
    BUS_WDATA, BUS_ACK_WR, BUS_RDATA, BUS_ACK_RD
  } bus_state_t;

  function automatic logic [11:0] ldo_millivolt(input logic [3:0] code);
    return BASE_MV + STEP_MV * {8'h00, code};
  endfunction

endpackage

// ### ldo_channel.sv
// one regulator: control register, output state and fault flag
// assumes overcurrent_i is already debounced and synchronous
`timescale 1ns/1ps
module ldo_channel
  import ldo_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic standby_i,
  input wire logic short_shutdown_enable_i,
  input wire logic overcurrent_i,
  input wire logic fault_clear_i,
  output ldo_ctrl_t ctrl_o,
  output ldo_mode_t mode_o,
  output logic [11:0] millivolt_o,
  output logic fault_flag_o
);

  // ==========================================================
  // control register
  ldo_ctrl_t ctrl;
  ldo_ctrl_t next_ctrl;
  ldo_mode_t mode;
  logic [11:0] millivolt;
  logic fault_flag;
  wire logic short_trip;
  wire logic next_fault_flag;

  assign short_trip = short_shutdown_enable_i & overcurrent_i;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_en_i) begin
      next_ctrl = ldo_ctrl_t'(wr_data_i);
    end
    next_ctrl.top = 1'b0;
    if (short_trip) begin
      next_ctrl.output_on = 1'b0;
    end
  end

  // overload always flags; a new event beats a clear
  assign next_fault_flag = overcurrent_i | (fault_flag & ~fault_clear_i);

  function automatic ldo_mode_t resolve(input ldo_ctrl_t c, input logic sb);
    if (!c.output_on) begin
      return LDO_OFF;
    end else if (!c.standby_keep || !sb) begin
      return c.low_power ? LDO_LOW_POWER : LDO_ON;
    end else begin
      return c.low_power ? LDO_LOW_POWER : LDO_OFF;
    end
  endfunction

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl <= CTRL_RESET;
      mode <= LDO_OFF;
      millivolt <= BASE_MV;
      fault_flag <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      mode <= resolve(next_ctrl, standby_i);
      millivolt <= ldo_millivolt(next_ctrl.voltage_code);
      fault_flag <= next_fault_flag;
    end
  end

  assign ctrl_o = ctrl;
  assign mode_o = mode;
  assign millivolt_o = millivolt;
  assign fault_flag_o = fault_flag;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_trip;
    short_trip;
  endsequence

  sequence s_off_flagged;
    !ctrl.output_on && fault_flag;
  endsequence

  chk_code_write: assert property (
    wr_en_i |=> ctrl.voltage_code == $past(wr_data_i[3:0]))
    else $error("voltage code not written");
  chk_output_switch: assert property (
    wr_en_i && !short_trip |=> ctrl.output_on == $past(wr_data_i[4]))
    else $error("output switch bit not written");
  chk_standby_keep: assert property (
    wr_en_i |=> ctrl.standby_keep == $past(wr_data_i[5]))
    else $error("standby keep bit not written");
  chk_low_power_mode: assert property (
    ctrl.output_on && ctrl.low_power && !wr_en_i && !short_trip
    |=> mode == LDO_LOW_POWER)
    else $error("low power not resolved");
  chk_standby_off: assert property (
    ctrl.output_on && !ctrl.low_power && ctrl.standby_keep && standby_i
    && !wr_en_i && !short_trip |=> mode == LDO_OFF)
    else $error("standby did not switch off");
  chk_short_trip: assert property (
    s_trip |=> s_off_flagged ##1 (mode == LDO_OFF || $past(wr_en_i)))
    else $error("short circuit did not shut down");
  chk_flag_only: assert property (
    overcurrent_i && !short_shutdown_enable_i && !wr_en_i
    |=> fault_flag && $stable(ctrl.output_on))
    else $error("overload without shutdown misbehaved");
  chk_top_zero: assert property (
    wr_en_i && wr_data_i[7] |=> !ctrl.top)
    else $error("top bit not zero");
  chk_reset_values: assert property (
    @(posedge clock_i) disable iff (1'b0)
    srst_i |=> ctrl == CTRL_RESET && !fault_flag)
    else $error("reset values wrong");

endmodule

// ### ldo_control_registers.sv
// regulator control register bank for regulators three to six behind a
// two-wire serial slave (address byte, pointer byte, data bytes)
// assumes scl_i and sda_i are synchronous to clock_i and the overcurrent
// inputs come from a debounced detector
//
// Summary of operation
// - bits 3:0 of each control register hold a read-write voltage code.
// - bit 4 switches the regulator output, 0 off and 1 on.
// - bit 5 chooses whether the output stays on during standby.
// - bit 6 forces the regulator into low-power operation.
// - the four control registers sit at consecutive addresses 0x6E to 0x71.
// - the voltage code loads the four low bits of default 0x80, code 0000.
// - bits 4 to 7 read zero after reset.
// - with shutdown enabled an overcurrent switches that regulator off.
// - output state follows enable, low-power, standby-keep and standby.
// - overload clears the enable when shutdown is on and always flags it.
// - shutdown is off after reset, so overloads only current limit; here short_shutdown_enable_i is an input that reset does not set.
// - codes 0000 to 1111 give 1.80 V to 3.30 V in 0.10 V steps.
`timescale 1ns/1ps
module ldo_control_registers
  import ldo_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic standby_i,
  input wire logic short_shutdown_enable_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic [3:0] fault_clear_i,
  input wire logic [3:0] ldo_fault_mask_i,
  output ldo_mode_t ldo_mode_o [LDO_COUNT],
  output logic [11:0] ldo_millivolt_o [LDO_COUNT],
  output logic [3:0] ldo_fault_flag_o,
  output logic fault_pending_o
);

  // ==========================================================
  // bus line sampling
  bus_state_t state;
  bus_state_t next_state;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic sda_oe;
  logic next_oe;
  logic bus_wr;
  ldo_ctrl_t ctrl [LDO_COUNT];

  wire logic scl_rise;
  wire logic scl_fall;
  wire logic start_seen;
  wire logic stop_seen;
  wire logic hit;
  wire logic [7:0] offset;
  wire logic [1:0] idx;
  wire logic [7:0] rd_byte;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;

  // ==========================================================
  // address decode
  assign hit = (ptr >= LDO3_CONTROL_ADDR) && (ptr <= LDO6_CONTROL_ADDR);
  assign offset = ptr - LDO3_CONTROL_ADDR;
  assign idx = offset[1:0];
  assign rd_byte = hit ? ctrl[idx] : UNMAPPED_READ;

  // ==========================================================
  // serial slave sequencer
  always_comb begin
    next_state = state;
    next_sh = sh;
    next_cnt = cnt;
    next_ptr = ptr;
    next_rw = rw;
    next_oe = sda_oe;
    bus_wr = 1'b0;
    if (start_seen) begin
      next_state = BUS_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = BUS_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        BUS_IDLE: begin
          next_oe = 1'b0;
        end
        BUS_ADDR, BUS_PTR, BUS_WDATA: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda_i};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_oe = 1'b1;
            if (state == BUS_ADDR) begin
              if (sh[7:1] == DEVICE_ADDR) begin
                next_rw = sh[0];
                next_state = BUS_ACK_ADDR;
              end else begin
                next_oe = 1'b0;
                next_state = BUS_IDLE;
              end
            end else if (state == BUS_PTR) begin
              next_ptr = sh;
              next_state = BUS_ACK_PTR;
            end else begin
              bus_wr = 1'b1;
              next_ptr = ptr + 8'h01;
              next_state = BUS_ACK_WR;
            end
          end
        end
        BUS_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw) begin
              next_sh = rd_byte;
              next_oe = ~rd_byte[7];
              next_state = BUS_RDATA;
            end else begin
              next_oe = 1'b0;
              next_state = BUS_PTR;
            end
          end
        end
        BUS_ACK_PTR, BUS_ACK_WR: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = BUS_WDATA;
          end
        end
        BUS_RDATA: begin
          if (scl_fall) begin
            if (cnt == 4'h7) begin
              next_cnt = 4'h0;
              next_oe = 1'b0;
              next_ptr = ptr + 8'h01;
              next_state = BUS_ACK_RD;
            end else begin
              next_cnt = cnt + 4'h1;
              next_sh = {sh[6:0], 1'b0};
              next_oe = ~sh[6];
            end
          end
        end
        BUS_ACK_RD: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda_i};
          end else if (scl_fall) begin
            if (!sh[0]) begin
              next_sh = rd_byte;
              next_oe = ~rd_byte[7];
              next_state = BUS_RDATA;
            end else begin
              next_state = BUS_IDLE;
            end
          end
        end
        default: begin
          next_state = BUS_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= BUS_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      scl_q <= scl_i;
      sda_q <= sda_i;
      sh <= next_sh;
      cnt <= next_cnt;
      ptr <= next_ptr;
      rw <= next_rw;
      sda_oe <= next_oe;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe;

  // ==========================================================
  // regulator channels
  for (genvar i = 0; i < LDO_COUNT; i++) begin : g_ldo
    wire logic wr_sel;
    assign wr_sel = bus_wr && hit && (idx == 2'(i));
    ldo_channel u_ldo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .wr_en_i(wr_sel),
      .wr_data_i(sh),
      .standby_i(standby_i),
      .short_shutdown_enable_i(short_shutdown_enable_i),
      .overcurrent_i(overcurrent_i[i]),
      .fault_clear_i(fault_clear_i[i]),
      .ctrl_o(ctrl[i]),
      .mode_o(ldo_mode_o[i]),
      .millivolt_o(ldo_millivolt_o[i]),
      .fault_flag_o(ldo_fault_flag_o[i])
    );
  end

  // unmasked flags summarise into one level
  assign fault_pending_o = |(ldo_fault_flag_o & ~ldo_fault_mask_i);

  // ==========================================================
  // checks
  chk_last_address: assert property (
    @(posedge clock_i) disable iff (srst_i)
    bus_wr && ptr == LDO6_CONTROL_ADDR
    |=> ctrl[3].voltage_code == $past(sh[3:0]))
    else $error("highest register not at expected address");
  chk_reset_code: assert property (
    @(posedge clock_i) srst_i |=> ctrl[0].voltage_code == VCODE_RESET
    && ldo_millivolt_o[2] == BASE_MV)
    else $error("reset voltage code wrong");
  chk_unmapped_read: assert property (
    @(posedge clock_i) disable iff (srst_i)
    state == BUS_ACK_ADDR && scl_fall && rw && !hit
    |=> sh == UNMAPPED_READ)
    else $error("unmapped read not zero");

endmodule

// ### ldo_control_registers_tb.sv
// self-checking bench for the regulator control register bank
// assumes the bank answers a two-wire master at DEVICE_ADDR with a pull-up
`timescale 1ns/1ps
module ldo_control_registers_tb
  import ldo_ctrl_pkg::*;
();
  // ==========================================================
  // stimulus and wiring
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  logic standby = 1'b0;
  logic shut_en = 1'b0;
  logic [3:0] oc = 4'h0;
  logic [3:0] fclr = 4'h0;
  logic [3:0] fmask = 4'h0;
  logic sda_out;
  logic sda_oe;
  ldo_mode_t mode [LDO_COUNT];
  logic [11:0] mv [LDO_COUNT];
  logic [3:0] flags;
  logic pending;
  // pull-up: the line is low only when one side pulls it low
  wire sda_line = sda_oe ? (sda_drv & sda_out) : sda_drv;
  typedef struct {string name; logic [11:0] e; logic [11:0] s;} note_t;
  note_t note_q[$];
  note_t cur;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] shadow [4] = '{default: 8'h00};
  logic [7:0] wdat [6];

  always #25 clock = ~clock;

  ldo_control_registers u_dut (
    .clock_i(clock), .srst_i(srst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .standby_i(standby),
    .short_shutdown_enable_i(shut_en), .overcurrent_i(oc),
    .fault_clear_i(fclr), .ldo_fault_mask_i(fmask),
    .ldo_mode_o(mode), .ldo_millivolt_o(mv),
    .ldo_fault_flag_o(flags), .fault_pending_o(pending)
  );

  // ==========================================================
  // scoreboard
  task automatic check(string n, logic [11:0] s, logic [11:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic note(string n, logic [11:0] e, logic [11:0] s);
    note_q.push_back('{n, e, s});
  endtask

  always @(negedge clock) begin
    while (note_q.size() > 0) begin
      cur = note_q.pop_front();
      check(cur.name, cur.s, cur.e);
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    stop_test();
  end

  // ==========================================================
  // serial master
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    @(negedge clock);
    r = sda_line;
    @(posedge clock);
    scl <= 1'b0;
    tick(1);
  endtask

  task automatic start_c();
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop_c();
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_drv <= 1'b1;
    tick(3);
  endtask

  // nak is the line level expected in the acknowledge slot
  task automatic put_byte(input logic [7:0] d, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    note("ack", {11'h000, nak}, {11'h000, r});
  endtask

  function automatic logic [7:0] exp_reg(logic [7:0] a);
    logic [7:0] k;
    k = a - LDO3_CONTROL_ADDR;
    return (k < 8'h04) ? shadow[k[1:0]] : UNMAPPED_READ;
  endfunction

  task automatic wr_regs(input logic [7:0] ptr, input int n);
    logic [7:0] a;
    start_c();
    put_byte({DEVICE_ADDR, 1'b0}, 1'b0);
    put_byte(ptr, 1'b0);
    for (int i = 0; i < n; i++) begin
      put_byte(wdat[i], 1'b0);
      a = ptr + 8'(i) - LDO3_CONTROL_ADDR;
      if (a < 8'h04) shadow[a[1:0]] = wdat[i] & 8'h7f;
    end
    stop_c();
  endtask

  task automatic rd_regs(input logic [7:0] ptr, input int n);
    logic r;
    logic [7:0] d;
    start_c();
    put_byte({DEVICE_ADDR, 1'b0}, 1'b0);
    put_byte(ptr, 1'b0);
    start_c();
    put_byte({DEVICE_ADDR, 1'b1}, 1'b0);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        d[i] = r;
      end
      bit_io(k == n - 1, r);
      note("rdata", {4'h0, exp_reg(ptr + 8'(k))}, {4'h0, d});
    end
    stop_c();
  endtask

  // ==========================================================
  // channel outputs
  function automatic ldo_mode_t exp_mode(ldo_ctrl_t c, logic s);
    if (!c.output_on) return LDO_OFF;
    if (!c.standby_keep || !s) return c.low_power ? LDO_LOW_POWER : LDO_ON;
    return c.low_power ? LDO_LOW_POWER : LDO_OFF;
  endfunction

  task automatic check_outs(input logic [3:0] f);
    @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      note("mode", 12'(exp_mode(shadow[i], standby)), 12'(mode[i]));
      note("mv", 12'h708 + 12'h064 * {8'h00, shadow[i][3:0]}, mv[i]);
    end
    note("flags", {8'h00, f}, {8'h00, flags});
  endtask

  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h0000_05c4));
    tick(10);
    srst <= 1'b0;
    tick(2);
    check_outs(4'h0);
    rd_regs(LDO3_CONTROL_ADDR, 4);
    $display("test reset done");
    for (int i = 0; i < 6; i++) wdat[i] = 8'($urandom);
    wr_regs(8'h6d, 6);
    rd_regs(8'h6d, 6);
    check_outs(4'h0);
    $display("test burst done");
    for (int j = 0; j < 8; j++) begin
      wdat[0] = 8'($urandom);
      standby <= 1'($urandom);
      wr_regs(LDO3_CONTROL_ADDR + 8'($urandom % 4), 1);
      tick(3);
      check_outs(4'h0);
    end
    // directed: on, bit 5 set so off in standby, full power, while in standby
    wdat[0] = 8'h34;
    standby <= 1'b1;
    wr_regs(LDO5_CONTROL_ADDR, 1);
    tick(3);
    check_outs(4'h0);
    standby <= 1'b0;
    $display("test modes done");
    start_c();
    put_byte({DEVICE_ADDR ^ 7'h01, 1'b0}, 1'b1);
    stop_c();
    rd_regs(LDO3_CONTROL_ADDR, 4);
    $display("test refuse done");
    wdat[0] = 8'h13;
    wdat[1] = 8'h15;
    wr_regs(LDO3_CONTROL_ADDR, 2);
    oc <= 4'b0001;
    tick(1);
    oc <= 4'h0;
    tick(2);
    check_outs(4'b0001);
    fmask <= 4'b0001;
    tick(2);
    note("pending", 12'h000, {11'h000, pending});
    fmask <= 4'h0;
    tick(2);
    note("pending", 12'h001, {11'h000, pending});
    fclr <= 4'b0001;
    tick(1);
    fclr <= 4'h0;
    shut_en <= 1'b1;
    oc <= 4'b0010;
    tick(1);
    oc <= 4'h0;
    tick(2);
    shadow[1][4] = 1'b0;
    check_outs(4'b0010);
    rd_regs(LDO3_CONTROL_ADDR, 4);
    $display("test fault done");
    tick(4);
    stop_test();
  end
endmodule
